/* rtl/lsb_top.sv */
// Logical signal bank: 32 logical outputs, 32 logical inputs, events and APB registers
//
// Summary of operation
// - Thirty-two logical outputs, each taken from a user logic signal.
// - Outputs route to protection blocking, group select, output relays and LEDs.
// - Every logical output state is readable by the supervisory system.
// - Each channel change gives an ON or OFF event carrying its index.
// - Per-function selection stores ON, OFF or both; unselected kinds dropped.
// - Each stored event carries a time stamp of its change.
// - Thirty-two logical inputs set by control commands, not physical pins.
// - After reboot every logical input starts at zero.
// - Hold mode: command 1 sets, stays until command 0 or reboot.
// - Pulse mode: command 1 sets, auto-return to zero after 5 ms.
//
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module lsb_top #(
  parameter int PULSE_CYCLES = lsb_pkg::PULSE_CYC
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [31:0] logic_out_src,
  input  wire logic        mimic_cmd_valid,
  input  wire logic [4:0]  mimic_cmd_chan,
  input  wire logic        mimic_cmd_value,
  output logic      [31:0] logic_in_channel,
  output logic      [31:0] prot_block,
  output logic             group_switch,
  output logic      [31:0] relay_drive,
  output logic      [31:0] led_drive,
  output logic             evt_valid,
  output logic      [31:0] output_event_block_on,
  output logic      [31:0] output_event_block_off,
  output logic      [31:0] input_event_block_on,
  output logic      [31:0] input_event_block_off,
  output logic      [31:0] evt_stamp,
  output logic             irq
);
  // ************************************************************
  // Functions
  // ************************************************************
  function automatic logic [31:0] onehot(input logic [4:0] idx);
    onehot = 32'h0000_0001 << idx;
  endfunction

  function automatic logic [31:0] wmask(input logic hit, input logic [31:0] d);
    wmask = hit ? d : lsb_pkg::ZERO32;
  endfunction

  // ************************************************************
  // Storage
  // ************************************************************
  logic [31:0]              logic_out_channel;
  logic [31:0]              lo_prev;
  logic [31:0]              li_prev;
  logic [31:0]              li_mode;
  logic [3:0]               evt_sel;
  logic [31:0]              rt_block;
  logic [31:0]              rt_group;
  logic [31:0]              rt_relay;
  logic [31:0]              rt_led;
  logic [2:0]               irq_stat;
  logic [2:0]               irq_mask;
  logic [lsb_pkg::DIV_W-1:0] div_cnt;
  logic                     us_tick;
  logic [31:0]              stamp;
  logic                     wr;
  logic                     setup;
  logic [31:0]              set_req;
  logic [31:0]              clr_req;
  logic [31:0]              next_li;
  logic [31:0]              lo_on;
  logic [31:0]              lo_off;
  logic [31:0]              li_on;
  logic [31:0]              li_off;
  logic [31:0]              next_rdata;
  logic                     next_err;
  lsb_pulse_if              pif ();

  lsb_pulse_bank #(.PULSE_CYCLES(PULSE_CYCLES)) u_bank (
    .clk  (clk),
    .rstn (rstn),
    .pif  (pif)
  );

  // ************************************************************
  // Bus decode
  // ************************************************************
  assign pready = 1'b1;
  assign wr     = psel && penable && pwrite;
  assign setup  = psel && !penable;

  // ************************************************************
  // Logical outputs
  // ************************************************************
  always_ff @(posedge clk)
  begin
    if (!rstn)
      logic_out_channel <= '0;
    else
      logic_out_channel <= logic_out_src;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      prot_block   <= '0;
      group_switch <= 1'b0;
      relay_drive  <= '0;
      led_drive    <= '0;
    end
    else
    begin
      prot_block   <= logic_out_channel & rt_block;
      group_switch <= |(logic_out_channel & rt_group);
      relay_drive  <= logic_out_channel & rt_relay;
      led_drive    <= logic_out_channel & rt_led;
    end
  end

  // ************************************************************
  // Logical input commands
  // ************************************************************
  // Mimic switch and bus writes merge into one request pair
  assign set_req = wmask(wr && paddr == lsb_pkg::OFS_CMD_ON, pwdata)
                 | wmask(mimic_cmd_valid && mimic_cmd_value, onehot(mimic_cmd_chan));
  assign clr_req = wmask(wr && paddr == lsb_pkg::OFS_CMD_OFF, pwdata)
                 | wmask(mimic_cmd_valid && !mimic_cmd_value, onehot(mimic_cmd_chan));
  assign pif.start = set_req & li_mode;

  always_comb
  begin
    // Set wins over clear in hold mode; pulse mode ignores clear
    next_li = (((logic_out_in_hold(logic_in_channel, clr_req)) | set_req) & ~li_mode)
            | (((logic_in_channel & ~pif.expire) | set_req) & li_mode);
  end

  function automatic logic [31:0] logic_out_in_hold(input logic [31:0] s, input logic [31:0] c);
    logic_out_in_hold = s & ~c;
  endfunction

  always_ff @(posedge clk)
  begin
    if (!rstn)
      logic_in_channel <= '0;
    else
      logic_in_channel <= next_li;
  end

  // ************************************************************
  // Time stamp
  // ************************************************************
  assign us_tick = (div_cnt == lsb_pkg::DIV_W'(lsb_pkg::STAMP_CYC - 1));

  always_ff @(posedge clk)
  begin
    if (!rstn || us_tick)
      div_cnt <= '0;
    else
      div_cnt <= div_cnt + 6'h01;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      stamp <= '0;
    else if (us_tick)
      stamp <= stamp + 32'h0000_0001;
  end

  // ************************************************************
  // Events
  // ************************************************************
  assign lo_on  = logic_out_channel & ~lo_prev & {32{evt_sel[lsb_pkg::SEL_OUT_ON]}};
  assign lo_off = ~logic_out_channel & lo_prev & {32{evt_sel[lsb_pkg::SEL_OUT_OFF]}};
  assign li_on  = logic_in_channel & ~li_prev & {32{evt_sel[lsb_pkg::SEL_IN_ON]}};
  assign li_off = ~logic_in_channel & li_prev & {32{evt_sel[lsb_pkg::SEL_IN_OFF]}};

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      lo_prev <= '0;
      li_prev <= '0;
    end
    else
    begin
      lo_prev <= logic_out_channel;
      li_prev <= logic_in_channel;
    end
  end

  // Bit position of each vector is the channel index
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      evt_valid              <= 1'b0;
      output_event_block_on  <= '0;
      output_event_block_off <= '0;
      input_event_block_on   <= '0;
      input_event_block_off  <= '0;
      evt_stamp              <= '0;
    end
    else
    begin
      evt_valid              <= |{lo_on, lo_off, li_on, li_off};
      output_event_block_on  <= lo_on;
      output_event_block_off <= lo_off;
      input_event_block_on   <= li_on;
      input_event_block_off  <= li_off;
      evt_stamp              <= stamp;
    end
  end

  // ************************************************************
  // Control registers
  // ************************************************************
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      li_mode  <= '0;
      evt_sel  <= lsb_pkg::EVT_SEL_RST;
      rt_block <= '0;
      rt_group <= '0;
      rt_relay <= '0;
      rt_led   <= '0;
      irq_mask <= '0;
    end
    else if (wr)
    begin
      unique case (paddr)
        lsb_pkg::OFS_LI_MODE:  li_mode  <= pwdata;
        lsb_pkg::OFS_EVT_SEL:  evt_sel  <= pwdata[3:0];
        lsb_pkg::OFS_RT_BLOCK: rt_block <= pwdata;
        lsb_pkg::OFS_RT_GROUP: rt_group <= pwdata;
        lsb_pkg::OFS_RT_RELAY: rt_relay <= pwdata;
        lsb_pkg::OFS_RT_LED:   rt_led   <= pwdata;
        lsb_pkg::OFS_IRQ_MASK: irq_mask <= pwdata[2:0];
        default:               li_mode  <= li_mode;
      endcase
    end
  end

  // ************************************************************
  // Interrupts
  // ************************************************************
  // New events win over a write-one clear in the same cycle
  always_ff @(posedge clk)
  begin
    if (!rstn)
      irq_stat <= '0;
    else
      irq_stat <= (irq_stat & ~3'(wmask(wr && paddr == lsb_pkg::OFS_IRQ_STAT, pwdata)))
                | {|(pif.expire & li_mode), |{li_on, li_off}, |{lo_on, lo_off}};
  end

  assign irq = |(irq_stat & irq_mask);

  // ************************************************************
  // Read path
  // ************************************************************
  always_comb
  begin
    next_err = 1'b0;
    unique case (paddr)
      lsb_pkg::OFS_LO_STATE: next_rdata = logic_out_channel;
      lsb_pkg::OFS_LI_STATE: next_rdata = logic_in_channel;
      lsb_pkg::OFS_LI_MODE:  next_rdata = li_mode;
      lsb_pkg::OFS_CMD_ON:   next_rdata = '0;
      lsb_pkg::OFS_CMD_OFF:  next_rdata = '0;
      lsb_pkg::OFS_EVT_SEL:  next_rdata = {28'h0000000, evt_sel};
      lsb_pkg::OFS_RT_BLOCK: next_rdata = rt_block;
      lsb_pkg::OFS_RT_GROUP: next_rdata = rt_group;
      lsb_pkg::OFS_RT_RELAY: next_rdata = rt_relay;
      lsb_pkg::OFS_RT_LED:   next_rdata = rt_led;
      lsb_pkg::OFS_IRQ_STAT: next_rdata = {29'h00000000, irq_stat};
      lsb_pkg::OFS_IRQ_MASK: next_rdata = {29'h00000000, irq_mask};
      lsb_pkg::OFS_STAMP:    next_rdata = stamp;
      default:
      begin
        next_rdata = '0;
        next_err   = 1'b1;
      end
    endcase
  end

  // Captured in setup, presented through the access cycle
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end
    else if (setup)
    begin
      prdata  <= pwrite ? lsb_pkg::ZERO32 : next_rdata;
      pslverr <= next_err;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_pulse_cmd;
    (set_req & li_mode) != 0;
  endsequence

  property p_lo_follow;
    1 |=> logic_out_channel == $past(logic_out_src);
  endproperty
  a_lo_follow: assert property (p_lo_follow) else $error("logical output lost source");

  property p_route;
    1 |=> ##1 relay_drive == $past(logic_out_channel & rt_relay)
              && prot_block == $past(logic_out_channel & rt_block);
  endproperty
  a_route: assert property (p_route) else $error("routing mismatch");

  property p_reboot;
    disable iff (1'b0) !rstn |=> logic_in_channel == 32'h0000_0000;
  endproperty
  a_reboot: assert property (p_reboot) else $error("input not zero after reset");

  property p_hold;
    (set_req & ~li_mode) != 0 |=>
      (logic_in_channel & $past(set_req & ~li_mode)) == $past(set_req & ~li_mode);
  endproperty
  a_hold: assert property (p_hold) else $error("hold set failed");

  property p_pulse_start;
    s_pulse_cmd |=> (logic_in_channel & $past(set_req & li_mode)) == $past(set_req & li_mode)
                    && (pif.active & $past(set_req & li_mode)) == $past(set_req & li_mode);
  endproperty
  a_pulse_start: assert property (p_pulse_start) else $error("pulse did not start");

  property p_pulse_noclr;
    (clr_req & li_mode & logic_in_channel & ~pif.expire) != 0 |=>
      (logic_in_channel & $past(clr_req & li_mode & logic_in_channel & ~pif.expire))
        == $past(clr_req & li_mode & logic_in_channel & ~pif.expire);
  endproperty
  a_pulse_noclr: assert property (p_pulse_noclr) else $error("pulse input cleared");

  property p_evt_on;
    (li_on != 0) |=> evt_valid && input_event_block_on == $past(li_on)
                     && evt_stamp == $past(stamp);
  endproperty
  a_evt_on: assert property (p_evt_on) else $error("input ON event missing");

  property p_sel_off;
    !evt_sel[lsb_pkg::SEL_OUT_OFF] |=> output_event_block_off == 32'h0000_0000;
  endproperty
  a_sel_off: assert property (p_sel_off) else $error("unselected event stored");

  property p_no_change;
    logic_in_channel == li_prev && logic_out_channel == lo_prev |=> !evt_valid;
  endproperty
  a_no_change: assert property (p_no_change) else $error("event without change");
endmodule
`default_nettype wire

/* rtl/lsb_pkg.sv */
// Package: register map, field layout, reset values and timing of the logical signal bank
package lsb_pkg;
  // ************************************************************
  // Sizes
  // ************************************************************
  localparam int          NCH        = 32;
  localparam int          PULSE_W    = 18;
  localparam int          STAMP_W    = 32;
  // ************************************************************
  // Timing
  // ************************************************************
  localparam int          CLK_HZ     = 40_000_000;
  localparam int          PULSE_MS   = 5;
  localparam int          PULSE_CYC  = PULSE_MS * (CLK_HZ / 1000);
  localparam int          STAMP_US   = 1;
  localparam int          STAMP_CYC  = STAMP_US * (CLK_HZ / 1_000_000);
  localparam int          DIV_W      = 6;
  // ************************************************************
  // Register byte offsets
  // ************************************************************
  localparam logic [7:0]  OFS_LO_STATE  = 8'h00;
  localparam logic [7:0]  OFS_LI_STATE  = 8'h04;
  localparam logic [7:0]  OFS_LI_MODE   = 8'h08;
  localparam logic [7:0]  OFS_CMD_ON    = 8'h0C;
  localparam logic [7:0]  OFS_CMD_OFF   = 8'h10;
  localparam logic [7:0]  OFS_EVT_SEL   = 8'h14;
  localparam logic [7:0]  OFS_RT_BLOCK  = 8'h18;
  localparam logic [7:0]  OFS_RT_GROUP  = 8'h1C;
  localparam logic [7:0]  OFS_RT_RELAY  = 8'h20;
  localparam logic [7:0]  OFS_RT_LED    = 8'h24;
  localparam logic [7:0]  OFS_IRQ_STAT  = 8'h28;
  localparam logic [7:0]  OFS_IRQ_MASK  = 8'h2C;
  localparam logic [7:0]  OFS_STAMP     = 8'h30;
  // ************************************************************
  // Fields and reset values
  // ************************************************************
  localparam int          SEL_OUT_ON  = 0;
  localparam int          SEL_OUT_OFF = 1;
  localparam int          SEL_IN_ON   = 2;
  localparam int          SEL_IN_OFF  = 3;
  localparam int          IRQ_OUT_EVT = 0;
  localparam int          IRQ_IN_EVT  = 1;
  localparam int          IRQ_PULSE   = 2;
  localparam logic [3:0]  EVT_SEL_RST = 4'hF;
  localparam logic [31:0] ZERO32      = 32'h0000_0000;
endpackage

/* rtl/lsb_pulse_if.sv */
// Interface: pulse-mode timer requests and expiries between controller and timer bank
`timescale 1ns/1ps
`default_nettype none
interface lsb_pulse_if;
  logic [31:0] start;
  logic [31:0] expire;
  logic [31:0] active;
  modport ctrl (output start, input expire, input active);
  modport bank (input start, output expire, output active);
endinterface
`default_nettype wire

/* rtl/lsb_pulse_bank.sv */
// Bank of per-channel pulse timers for logical inputs in pulse mode
`timescale 1ns/1ps
`default_nettype none
module lsb_pulse_bank #(
  parameter int PULSE_CYCLES = lsb_pkg::PULSE_CYC
) (
  input  wire logic  clk,
  input  wire logic  rstn,
  lsb_pulse_if.bank  pif
);
  localparam logic [lsb_pkg::PULSE_W-1:0] LOAD = lsb_pkg::PULSE_W'(PULSE_CYCLES);
  localparam logic [lsb_pkg::PULSE_W-1:0] ONE  = 18'h00001;
  logic [lsb_pkg::PULSE_W-1:0] cnt [lsb_pkg::NCH];

  for (genvar i = 0; i < lsb_pkg::NCH; i++)
  begin : g_ch
    // Start or restart reloads the count to PULSE_CYCLES
    always_ff @(posedge clk)
    begin
      if (!rstn)
        cnt[i] <= '0;
      else if (pif.start[i])
        cnt[i] <= LOAD;
      else if (cnt[i] != '0)
        cnt[i] <= cnt[i] - ONE;
    end
    assign pif.expire[i] = (cnt[i] == ONE) && !pif.start[i];
    assign pif.active[i] = (cnt[i] != '0);
  end
endmodule
`default_nettype wire

/* testbench/lsb_far_side.sv */
// Far-side model: mimic virtual switch and user logic sources
`timescale 1ns/1ps
`default_nettype none
module lsb_far_side (
  input  wire logic        clk,
  input  wire logic [31:0] logic_in_channel,
  output logic             mimic_cmd_valid,
  output logic [4:0]       mimic_cmd_chan,
  output logic             mimic_cmd_value,
  output logic [31:0]      logic_out_src
);
  initial
  begin
    mimic_cmd_valid = 1'b0;
    mimic_cmd_chan  = 5'h00;
    mimic_cmd_value = 1'b0;
    logic_out_src   = 32'h0000_0000;
  end

  // One-cycle switch command; lines scrambled while idle
  task automatic mimic(input logic [4:0] ch, input logic v);
    @(posedge clk);
    mimic_cmd_valid <= 1'b1;
    mimic_cmd_chan  <= ch;
    mimic_cmd_value <= v;
    @(posedge clk);
    mimic_cmd_valid <= 1'b0;
    mimic_cmd_chan  <= ~ch;
    mimic_cmd_value <= ~v;
  endtask

  task automatic drive_src(input logic [31:0] v);
    @(posedge clk);
    logic_out_src <= v;
  endtask

  // User logic off-delay gate: pulsed input stretched onto a logical output
  task automatic stretch(input int li, input int lo, input int hold);
    int left = 0;
    int seen = 0;
    while (seen == 0 || left > 0)
    begin
      @(posedge clk);
      if (logic_in_channel[li] === 1'b1)
      begin
        seen = 1;
        left = hold;
      end
      else if (left > 0)
        left--;
      logic_out_src[lo] <= (left > 0);
    end
  endtask
endmodule
`default_nettype wire

/* testbench/lsb_top_test.sv */
// Self-checking testbench of the logical signal bank
`timescale 1ns/1ps
`default_nettype none
module lsb_top_test;
  typedef struct {logic [7:0] a; logic [31:0] d; logic e;} lsb_row_t;
  localparam int PCYC = 20;

  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, logic_in_channel, prot_block, relay_drive, led_drive;
  logic [31:0] oon, ooff, ion, ioff, evt_stamp, logic_out_src;
  logic        pready, pslverr, group_switch, evt_valid, irq;
  logic        mimic_cmd_valid, mimic_cmd_value;
  logic [4:0]  mimic_cmd_chan;
  logic [31:0] acc_oon, acc_ooff, acc_ion, acc_ioff, last_stamp, n_evt, rd, cnt;
  logic        er;
  int          miscompares = 0;
  int          samples_checked = 0;
  lsb_row_t    rows [10] = '{
    '{lsb_pkg::OFS_LO_STATE, 32'h0000_0000, 1'b0},
    '{lsb_pkg::OFS_LI_STATE, 32'h0000_0000, 1'b0},
    '{lsb_pkg::OFS_LI_MODE, 32'h0000_0000, 1'b0},
    '{lsb_pkg::OFS_CMD_ON, 32'h0000_0000, 1'b0},
    '{lsb_pkg::OFS_CMD_OFF, 32'h0000_0000, 1'b0},
    '{lsb_pkg::OFS_EVT_SEL, 32'h0000_000F, 1'b0},
    '{lsb_pkg::OFS_RT_BLOCK, 32'h0000_0000, 1'b0},
    '{lsb_pkg::OFS_RT_LED, 32'h0000_0000, 1'b0},
    '{lsb_pkg::OFS_IRQ_MASK, 32'h0000_0000, 1'b0},
    '{8'h34, 32'h0000_0000, 1'b1}};

  always #12.5 clk = ~clk;

  lsb_top #(.PULSE_CYCLES(PCYC)) i_dut (
    .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .logic_out_src(logic_out_src),
    .mimic_cmd_valid(mimic_cmd_valid), .mimic_cmd_chan(mimic_cmd_chan),
    .mimic_cmd_value(mimic_cmd_value), .logic_in_channel(logic_in_channel),
    .prot_block(prot_block), .group_switch(group_switch), .relay_drive(relay_drive),
    .led_drive(led_drive), .evt_valid(evt_valid), .output_event_block_on(oon),
    .output_event_block_off(ooff), .input_event_block_on(ion),
    .input_event_block_off(ioff), .evt_stamp(evt_stamp), .irq(irq));

  lsb_far_side i_far (
    .clk(clk), .logic_in_channel(logic_in_channel), .mimic_cmd_valid(mimic_cmd_valid),
    .mimic_cmd_chan(mimic_cmd_chan),
    .mimic_cmd_value(mimic_cmd_value), .logic_out_src(logic_out_src));

  // Event collector
  always @(posedge clk)
    if (evt_valid === 1'b1)
    begin
      acc_oon    <= acc_oon | oon;
      acc_ooff   <= acc_ooff | ooff;
      acc_ion    <= acc_ion | ion;
      acc_ioff   <= acc_ioff | ioff;
      last_stamp <= evt_stamp;
      n_evt      <= n_evt + 32'h0000_0001;
    end

  task automatic clr();
    {acc_oon, acc_ooff, acc_ion, acc_ioff, n_evt} = '0;
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic close_out();
    if (miscompares == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    #(25ns * 20000);
    miscompares++;
    close_out();
  end

  initial
  begin
    clr();
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    foreach (rows[i])
    begin
      apb(1'b0, rows[i].a, 32'h0000_0000);
      chk32("reg", rows[i].d, rd);
      chk32("err", {31'h0, rows[i].e}, {31'h0, er});
    end
    // ************************************************************
    // Logical outputs, routes and events
    // ************************************************************
    apb(1'b1, lsb_pkg::OFS_RT_BLOCK, 32'hFFFF_FFFF);
    apb(1'b1, lsb_pkg::OFS_RT_RELAY, 32'hFFFF_FFFF);
    apb(1'b1, lsb_pkg::OFS_RT_LED, 32'hFFFF_FFFF);
    apb(1'b1, lsb_pkg::OFS_RT_GROUP, 32'h0000_0020);
    wait_n(1);
    clr();
    i_far.drive_src(32'h0000_00A5);
    wait_n(4);
    chk32("prot_block", 32'h0000_00A5, prot_block);
    chk32("relay_drive", 32'h0000_00A5, relay_drive);
    chk32("led_drive", 32'h0000_00A5, led_drive);
    chk32("group_switch", 32'h1, {31'h0, group_switch});
    chk32("out_on", 32'h0000_00A5, acc_oon);
    chk32("out_off", 32'h0000_0000, acc_ooff);
    apb(1'b0, lsb_pkg::OFS_LO_STATE, 32'h0000_0000);
    chk32("lo_state", 32'h0000_00A5, rd);
    apb(1'b0, lsb_pkg::OFS_STAMP, 32'h0000_0000);
    chk32("stamp_order", 32'h1, {31'h0, last_stamp <= rd});
    // Two stamp reads captured exactly 400 cycles apart
    cnt = rd;
    wait_n(397);
    apb(1'b0, lsb_pkg::OFS_STAMP, 32'h0000_0000);
    chk32("stamp_rate", 400 / lsb_pkg::STAMP_CYC, rd - cnt);
    // Only ON kinds selected
    apb(1'b1, lsb_pkg::OFS_EVT_SEL, 32'h0000_0005);
    wait_n(1);
    clr();
    i_far.drive_src(32'h0000_0000);
    wait_n(4);
    chk32("sel_off", 32'h0000_0000, acc_ooff | n_evt);
    apb(1'b1, lsb_pkg::OFS_EVT_SEL, 32'h0000_000F);
    // ************************************************************
    // Hold mode inputs
    // ************************************************************
    wait_n(1);
    clr();
    apb(1'b1, lsb_pkg::OFS_CMD_ON, 32'h0000_0008);
    wait_n(40);
    chk32("hold", 32'h0000_0008, logic_in_channel);
    chk32("in_on", 32'h0000_0008, acc_ion);
    clr();
    apb(1'b1, lsb_pkg::OFS_CMD_ON, 32'h0000_0008);
    wait_n(3);
    chk32("same_state", 32'h0000_0000, n_evt);
    apb(1'b1, lsb_pkg::OFS_CMD_OFF, 32'h0000_0008);
    wait_n(3);
    chk32("hold_off", 32'h0000_0000, logic_in_channel);
    chk32("in_off", 32'h0000_0008, acc_ioff);
    // ************************************************************
    // Pulse mode, retrigger and interrupt
    // ************************************************************
    apb(1'b1, lsb_pkg::OFS_IRQ_STAT, 32'hFFFF_FFFF);
    apb(1'b1, lsb_pkg::OFS_IRQ_MASK, 32'h0000_0004);
    apb(1'b1, lsb_pkg::OFS_LI_MODE, 32'h0000_0080);
    i_far.mimic(5'h07, 1'b1);
    wait_n(8);
    i_far.mimic(5'h07, 1'b0);
    #1;
    chk32("pulse_zero_cmd", 32'h0000_0080, logic_in_channel);
    i_far.mimic(5'h07, 1'b1);
    #1;
    cnt = 32'h0;
    while (logic_in_channel[7] === 1'b1 && cnt < 32'd100)
    begin
      cnt++;
      @(posedge clk);
      #1;
    end
    chk32("pulse_len", PCYC, cnt);
    wait_n(2);
    chk32("irq_on", 32'h1, {31'h0, irq});
    apb(1'b0, lsb_pkg::OFS_IRQ_STAT, 32'h0000_0000);
    chk32("irq_stat", 32'h0000_0006, rd);
    apb(1'b1, lsb_pkg::OFS_IRQ_MASK, 32'h0000_0000);
    wait_n(1);
    chk32("irq_masked", 32'h0, {31'h0, irq});
    apb(1'b1, lsb_pkg::OFS_IRQ_MASK, 32'h0000_0004);
    apb(1'b1, lsb_pkg::OFS_IRQ_STAT, 32'h0000_0004);
    wait_n(1);
    chk32("irq_cleared", 32'h0, {31'h0, irq});
    // Pulse stretched by user logic onto logical output 0
    clr();
    fork
      i_far.mimic(5'h07, 1'b1);
      i_far.stretch(7, 0, 30);
      begin
        wait_n(PCYC + 10);
        chk32("stretch", 32'h1, {30'h0, logic_in_channel[7], relay_drive[0]});
      end
    join
    wait_n(3);
    chk32("stretch_off", 32'h1, acc_ooff & 32'h0000_0001);
    // ************************************************************
    // Reboot clears inputs
    // ************************************************************
    apb(1'b1, lsb_pkg::OFS_LI_MODE, 32'h0000_0000);
    apb(1'b1, lsb_pkg::OFS_CMD_ON, 32'hFFFF_FFFF);
    wait_n(2);
    chk32("all_on", 32'hFFFF_FFFF, logic_in_channel);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    wait_n(1);
    chk32("reboot", 32'h0000_0000, logic_in_channel);
    apb(1'b0, lsb_pkg::OFS_EVT_SEL, 32'h0000_0000);
    chk32("evt_sel", 32'h0000_000F, rd);
    close_out();
  end
endmodule
`default_nettype wire
